/* File: hdl/ouda_consts.vh */
// constants for the otp user data array: addresses, layouts, reset values
`ifndef OUDA_CONSTS_VH
`define OUDA_CONSTS_VH
`define OUDA_ADDR_IDENT0 8'h00
`define OUDA_ADDR_IDENT1 8'h01
`define OUDA_ADDR_IDENT2 8'h02
`define OUDA_ADDR_IDENT3 8'h03
`define OUDA_ADDR_RANGE_CFG 8'h04
`define OUDA_ADDR_LINK_CFG 8'h05
`define OUDA_ADDR_MODE_SLOT_HI 8'h06
`define OUDA_ADDR_SLOT_A_LO 8'h07
`define OUDA_ADDR_SLOT_B_LO 8'h08
`define OUDA_ADDR_INIT_REV 8'h09
`define OUDA_ADDR_DATE_MY 8'h0a
`define OUDA_ADDR_DATE_DAY 8'h0b
`define OUDA_ADDR_SELF_CHECK 8'h0c
`define OUDA_ADDR_MAKER 8'h0d
`define OUDA_ADDR_LAST 8'h0d
`define OUDA_NIB_ADDR_LAST 8'h1b
`define OUDA_USER_FIRST 8'h05
`define OUDA_USER_COUNT 4'h9
`define OUDA_FACT_COUNT 4'h5
`define OUDA_RANGE_PATTERN 5'h04
`define OUDA_RANGE_CFG_RESET 8'h20
`define OUDA_LOCK_BIT 7
`define OUDA_UNIT_MSB 12
`define OUDA_LOT_LSB 13
`define OUDA_LOAD_STEPS 4'hf
`define OUDA_CRC_POLY 8'h07
`endif

/* File: hdl/ouda_crc8.v */
// crc-8 check over a shadowed otp block, one byte per step
`timescale 1ns/10ps
`default_nettype none
module ouda_crc8 (
    // clock and reset
    input wire clk_in,
    input wire srst_in,
    // byte stream
    input wire start_in,
    input wire byte_valid_in,
    input wire [7:0] byte_in,
    // result
    output reg [7:0] crc_out
);
`include "ouda_consts.vh"

    // one byte folded into the running remainder
    function [7:0] ouda_crc_step;
        input [7:0] crc;
        input [7:0] data;
        integer i;
        reg [7:0] c;
        begin
            c = crc ^ data;
            for (i = 0; i < 8; i = i + 1) begin
                c = c[7] ? ((c << 1) ^ `OUDA_CRC_POLY) : (c << 1);
            end
            ouda_crc_step = c;
        end
    endfunction

    // remainder register
    always @(posedge clk_in) begin
        if (srst_in || start_in) begin
            crc_out <= 8'h00;
        end else if (byte_valid_in) begin
            crc_out <= ouda_crc_step(crc_out, byte_in);
        end
    end
endmodule
`default_nettype wire

/* File: hdl/ouda_array.v */
// otp user data array: shadow load, readout, user programming and lock
`timescale 1ns/10ps
`default_nettype none
module ouda_array #(
    parameter FACT_CRC_REF = 8'h00,
    parameter USER_CRC_REF = 8'h00
) (
    // clock and reset
    input wire CLK_IN,
    input wire SRST_IN,
    // otp cells as seen by the array, and the self check status byte
    input wire [39:0] FACT_OTP_IN,
    input wire [71:0] USER_OTP_IN,
    input wire [7:0] SELF_CHECK_IN,
    // read request from the link
    input wire RD_REQ_IN,
    input wire RD_NIBBLE_IN,
    input wire [7:0] RD_ADDR_IN,
    // programming request from the link
    input wire PROG_REQ_IN,
    input wire [7:0] PROG_ADDR_IN,
    input wire [7:0] PROG_DATA_IN,
    // otp burn port
    output reg OTP_BURN_OUT,
    output reg [3:0] OTP_BURN_IDX_OUT,
    output reg [7:0] OTP_BURN_DATA_OUT,
    input wire OTP_BURN_DONE_IN,
    // answers
    output reg RD_VALID_OUT,
    output reg [7:0] RD_DATA_OUT,
    output reg PROG_ACK_OUT,
    output reg PROG_REFUSED_OUT,
    // status
    output wire READY_OUT,
    output reg FACT_CRC_ERR_OUT,
    output reg USER_CRC_ERR_OUT,
    output wire USER_LOCKED_OUT,
    output wire [2:0] RANGE_FIELD_OUT,
    output wire [3:0] INIT_NIBBLE_NINE_OUT,
    output wire [12:0] UNIT_COUNT_OUT,
    output wire [18:0] LOT_NUMBER_OUT
);
`include "ouda_consts.vh"

    localparam ST_LOAD = 2'd0;
    localparam ST_CHECK = 2'd1;
    localparam ST_RUN = 2'd2;
    localparam ST_BURN = 2'd3;

    // sequencer state
    reg [1:0] state;
    reg [3:0] step;
    wire check_done;
    // shadow copies of both otp blocks
    reg [7:0] fact_mem [0:4];
    reg [7:0] user_mem [0:8];
    // readout path
    reg [7:0] rd_byte;
    reg [7:0] next_rd_data;
    wire [7:0] byte_addr;
    wire rd_take;
    // crc engines
    wire fact_crc_start;
    wire user_crc_start;
    wire fact_crc_valid;
    wire user_crc_valid;
    wire [7:0] fact_crc;
    wire [7:0] user_crc;
    wire [7:0] fact_crc_byte;
    wire [7:0] user_crc_byte;
    integer k;

    // init nibble nine straight from the range code table
    function [3:0] ouda_nibble_nine;
        input [2:0] code;
        begin
            case (code)
                3'b000: begin
                    ouda_nibble_nine = 4'h1;
                end
                3'b001: begin
                    ouda_nibble_nine = 4'h7;
                end
                3'b010: begin
                    ouda_nibble_nine = 4'h2;
                end
                3'b011: begin
                    ouda_nibble_nine = 4'h8;
                end
                3'b100: begin
                    ouda_nibble_nine = 4'h3;
                end
                3'b101: begin
                    ouda_nibble_nine = 4'h9;
                end
                3'b110: begin
                    ouda_nibble_nine = 4'h4;
                end
                3'b111: begin
                    ouda_nibble_nine = 4'ha;
                end
                default: begin
                    ouda_nibble_nine = 4'h1;
                end
            endcase
        end
    endfunction

    // user block index of a user byte address, for the burn port and the readout
    function [3:0] ouda_user_index;
        input [7:0] addr;
        reg [7:0] offset;
        begin
            offset = addr - `OUDA_USER_FIRST;
            ouda_user_index = offset[3:0];
        end
    endfunction

    // a programming request may only touch an unlocked user byte
    function ouda_prog_allowed;
        input [7:0] addr;
        input locked;
        begin
            ouda_prog_allowed = 1'b1;
            if (addr < `OUDA_USER_FIRST) begin
                // factory block is burned at manufacture only
                ouda_prog_allowed = 1'b0;
            end
            if (addr > `OUDA_ADDR_LAST) begin
                ouda_prog_allowed = 1'b0;
            end
            if (addr == `OUDA_ADDR_SELF_CHECK) begin
                // status byte has no otp cell behind it
                ouda_prog_allowed = 1'b0;
            end
            if (locked) begin
                // lock bit as read back from the otp
                ouda_prog_allowed = 1'b0;
            end
        end
    endfunction

    // nibble half of a byte: even address takes bits 3:0, odd takes bits 7:4
    function [7:0] ouda_nibble_pick;
        input [7:0] data;
        input odd;
        begin
            if (odd) begin
                ouda_nibble_pick = {4'h0, data[7:4]};
            end else begin
                ouda_nibble_pick = {4'h0, data[3:0]};
            end
        end
    endfunction

    // shadow load sequence, then crc check, then service
    always @(posedge CLK_IN) begin
        if (SRST_IN) begin
            state <= ST_LOAD;
            step <= 4'h0;
            OTP_BURN_OUT <= 1'b0;
            OTP_BURN_IDX_OUT <= 4'h0;
            OTP_BURN_DATA_OUT <= 8'h00;
            PROG_ACK_OUT <= 1'b0;
            PROG_REFUSED_OUT <= 1'b0;
            for (k = 0; k < 5; k = k + 1) begin
                fact_mem[k] <= 8'h00;
            end
            for (k = 0; k < 9; k = k + 1) begin
                user_mem[k] <= 8'h00;
            end
            fact_mem[4] <= `OUDA_RANGE_CFG_RESET;
        end else begin
            PROG_ACK_OUT <= 1'b0;
            PROG_REFUSED_OUT <= 1'b0;
            case (state)
                ST_LOAD: begin
                    // copy otp into shadows in one step
                    for (k = 0; k < 5; k = k + 1) begin
                        fact_mem[k] <= FACT_OTP_IN[k*8 +: 8];
                    end
                    for (k = 0; k < 9; k = k + 1) begin
                        user_mem[k] <= USER_OTP_IN[k*8 +: 8];
                    end
                    step <= 4'h0;
                    state <= ST_CHECK;
                end
                ST_CHECK: begin
                    // both checkers walk their own block side by side
                    if (check_done) begin
                        state <= ST_RUN;
                    end else begin
                        step <= step + 4'h1;
                    end
                end
                ST_RUN: begin
                    if (PROG_REQ_IN) begin
                        // factory, status, unmapped or locked bytes are refused
                        if (!ouda_prog_allowed(PROG_ADDR_IN, USER_LOCKED_OUT)) begin
                            PROG_REFUSED_OUT <= 1'b1;
                        end else begin
                            // burn the user cell through the otp port
                            OTP_BURN_OUT <= 1'b1;
                            OTP_BURN_IDX_OUT <= ouda_user_index(PROG_ADDR_IN);
                            OTP_BURN_DATA_OUT <= PROG_DATA_IN;
                            state <= ST_BURN;
                        end
                    end
                end
                ST_BURN: begin
                    if (OTP_BURN_DONE_IN) begin
                        // read back the otp so a burned lock takes effect
                        OTP_BURN_OUT <= 1'b0;
                        PROG_ACK_OUT <= 1'b1;
                        state <= ST_LOAD;
                    end
                end
                default: begin
                    state <= ST_LOAD;
                end
            endcase
        end
    end

    assign READY_OUT = (state == ST_RUN);
    assign USER_LOCKED_OUT = user_mem[0][`OUDA_LOCK_BIT];
    // check pass ends once the longer user block is through
    assign check_done = (state == ST_CHECK) && (step == `OUDA_USER_COUNT);
    // a read is taken only once the shadows are loaded and checked
    assign rd_take = RD_REQ_IN && READY_OUT;

    assign fact_crc_start = (state == ST_LOAD);
    assign user_crc_start = (state == ST_LOAD);
    assign fact_crc_valid = (state == ST_CHECK) && (step < `OUDA_FACT_COUNT);
    assign user_crc_valid = (state == ST_CHECK) && (step < `OUDA_USER_COUNT);
    // factory crc covers ident bytes and the range byte
    assign fact_crc_byte = (step < `OUDA_FACT_COUNT) ? fact_mem[step[2:0]] : 8'h00;
    assign user_crc_byte = (step < `OUDA_USER_COUNT) ? user_mem[step] : 8'h00;

    ouda_crc8 u_fact_crc (
        .clk_in(CLK_IN),
        .srst_in(SRST_IN),
        .start_in(fact_crc_start),
        .byte_valid_in(fact_crc_valid),
        .byte_in(fact_crc_byte),
        .crc_out(fact_crc)
    );

    ouda_crc8 u_user_crc (
        .clk_in(CLK_IN),
        .srst_in(SRST_IN),
        .start_in(user_crc_start),
        .byte_valid_in(user_crc_valid),
        .byte_in(user_crc_byte),
        .crc_out(user_crc)
    );

    // crc verdicts latched at the end of the check pass
    always @(posedge CLK_IN) begin
        if (SRST_IN) begin
            FACT_CRC_ERR_OUT <= 1'b0;
            USER_CRC_ERR_OUT <= 1'b0;
        end else if (check_done) begin
            FACT_CRC_ERR_OUT <= (fact_crc != FACT_CRC_REF);
            USER_CRC_ERR_OUT <= (user_crc != USER_CRC_REF);
        end
    end

    // nibble addresses fold onto byte addresses
    assign byte_addr = RD_NIBBLE_IN ? {1'b0, RD_ADDR_IN[7:1]} : RD_ADDR_IN;

    // byte lookup over the readable map; anything past it reads zero
    always @* begin
        rd_byte = 8'h00;
        case (byte_addr)
            `OUDA_ADDR_IDENT0: begin
                rd_byte = fact_mem[0];
            end
            `OUDA_ADDR_IDENT1: begin
                rd_byte = fact_mem[1];
            end
            `OUDA_ADDR_IDENT2: begin
                rd_byte = fact_mem[2];
            end
            `OUDA_ADDR_IDENT3: begin
                rd_byte = fact_mem[3];
            end
            `OUDA_ADDR_RANGE_CFG: begin
                // fixed pattern over the range field
                rd_byte = {`OUDA_RANGE_PATTERN, fact_mem[4][2:0]};
            end
            `OUDA_ADDR_SELF_CHECK: begin
                rd_byte = SELF_CHECK_IN;
            end
            `OUDA_ADDR_LINK_CFG,
            `OUDA_ADDR_MODE_SLOT_HI,
            `OUDA_ADDR_SLOT_A_LO,
            `OUDA_ADDR_SLOT_B_LO,
            `OUDA_ADDR_INIT_REV,
            `OUDA_ADDR_DATE_MY,
            `OUDA_ADDR_DATE_DAY,
            `OUDA_ADDR_MAKER: begin
                rd_byte = user_mem[ouda_user_index(byte_addr)];
            end
            default: begin
                rd_byte = 8'h00;
            end
        endcase
    end

    // pick the nibble half for long messages
    always @* begin
        if (RD_NIBBLE_IN && (RD_ADDR_IN > `OUDA_NIB_ADDR_LAST)) begin
            // nibble addresses past the map read zero
            next_rd_data = 8'h00;
        end else if (RD_NIBBLE_IN) begin
            next_rd_data = ouda_nibble_pick(rd_byte, RD_ADDR_IN[0]);
        end else begin
            next_rd_data = rd_byte;
        end
    end

    // read answer one cycle after a request, only once shadows are valid
    always @(posedge CLK_IN) begin
        if (SRST_IN) begin
            RD_VALID_OUT <= 1'b0;
            RD_DATA_OUT <= 8'h00;
        end else begin
            RD_VALID_OUT <= rd_take;
            if (rd_take) begin
                RD_DATA_OUT <= next_rd_data;
            end
        end
    end

    // range field and its init nibble
    assign RANGE_FIELD_OUT = fact_mem[4][2:0];
    assign INIT_NIBBLE_NINE_OUT = ouda_nibble_nine(fact_mem[4][2:0]);
    // ident number split, for traceability only
    assign UNIT_COUNT_OUT = {fact_mem[1][4:0], fact_mem[0]};
    assign LOT_NUMBER_OUT = {fact_mem[3], fact_mem[2], fact_mem[1][7:5]};
endmodule
`default_nettype wire

/* File: verif/ouda_array_monitor.sv */
// assertion checker watching the otp user data array ports
`timescale 1ns/10ps
`default_nettype none
module ouda_monitor (
    // clock and reset
    input wire logic CLK_IN,
    input wire logic SRST_IN,
    // requests from the link and the otp
    input wire logic RD_REQ_IN,
    input wire logic RD_NIBBLE_IN,
    input wire logic [7:0] RD_ADDR_IN,
    input wire logic PROG_REQ_IN,
    input wire logic [7:0] PROG_ADDR_IN,
    input wire logic OTP_BURN_DONE_IN,
    // answers and status
    input wire logic OTP_BURN_OUT,
    input wire logic RD_VALID_OUT,
    input wire logic [7:0] RD_DATA_OUT,
    input wire logic PROG_ACK_OUT,
    input wire logic PROG_REFUSED_OUT,
    input wire logic READY_OUT,
    input wire logic USER_LOCKED_OUT,
    input wire logic [2:0] RANGE_FIELD_OUT,
    input wire logic [3:0] INIT_NIBBLE_NINE_OUT
);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (SRST_IN);
    // requests that the array takes
    wire rd_ok = RD_REQ_IN && READY_OUT;
    wire pg_ok = PROG_REQ_IN && READY_OUT;
    a_read_answer:
        assert property (rd_ok |=> RD_VALID_OUT) else $error("read not answered");
    a_no_early_read:
        assert property (RD_REQ_IN && !READY_OUT |=> !RD_VALID_OUT) else $error("early answer");
    a_high_addr_zero:
        assert property (rd_ok && !RD_NIBBLE_IN && RD_ADDR_IN > 8'h0d |=> RD_DATA_OUT == 8'h00)
        else $error("high address not zero");
    a_nibble_upper:
        assert property (rd_ok && RD_NIBBLE_IN |=> RD_DATA_OUT[7:4] == 4'h0)
        else $error("nibble upper bits set");
    a_range_byte:
        assert property (rd_ok && !RD_NIBBLE_IN && RD_ADDR_IN == 8'h04
            |=> RD_DATA_OUT == {5'b00100, RANGE_FIELD_OUT}) else $error("range byte wrong");
    a_fact_refused:
        assert property (pg_ok && PROG_ADDR_IN < 8'h05 |=> PROG_REFUSED_OUT && !OTP_BURN_OUT)
        else $error("factory write taken");
    a_lock_refused:
        assert property (pg_ok && USER_LOCKED_OUT |=> PROG_REFUSED_OUT) else $error("lock ignored");
    a_burn_ack:
        assert property (OTP_BURN_OUT && OTP_BURN_DONE_IN |=> PROG_ACK_OUT && !OTP_BURN_OUT)
        else $error("burn not acknowledged");
    a_ready_return:
        assert property ($rose(PROG_ACK_OUT) |-> ##[1:30] READY_OUT) else $error("no reload");
    a_nibble_nine:
        assert property (INIT_NIBBLE_NINE_OUT ==
            ((32'hA493_8271 >> {RANGE_FIELD_OUT, 2'b00}) & 32'h0000_000f))
        else $error("init nibble wrong");
    // main scenarios seen
    c_nib_read: cover property (rd_ok && RD_NIBBLE_IN);
    c_ack: cover property (PROG_ACK_OUT);
    c_refused: cover property (PROG_REFUSED_OUT);
endmodule
`default_nettype wire

/* File: verif/ouda_otp_model.sv */
// otp cell model: holds the user bytes and burns them on request
`timescale 1ns/10ps
`default_nettype none
module ouda_otp_model (
    // clock
    input wire logic clk_in,
    // burn port
    input wire logic burn_in,
    input wire logic [3:0] idx_in,
    input wire logic [7:0] data_in,
    input wire logic [7:0] delay_in,
    output logic done_out,
    // cell contents
    output logic [71:0] user_out
);
    logic [7:0] cnt;
    // blank cells at power up
    initial begin
        user_out = 72'h0;
        done_out = 1'b0;
        cnt = 8'h00;
    end
    // only user cells burn, and a burn can only set bits
    always @(posedge clk_in) begin
        done_out <= 1'b0;
        if (!burn_in)
            cnt <= 8'h00;
        else if (cnt == delay_in) begin
            done_out <= 1'b1;
            cnt <= cnt + 8'h01;
            user_out[{idx_in, 3'b000} +: 8] <= user_out[{idx_in, 3'b000} +: 8] | data_in;
        end else if (cnt < delay_in)
            cnt <= cnt + 8'h01;
    end
endmodule
`default_nettype wire

/* File: verif/otp_user_data_array_test.sv */
// self-checking bench for the otp user data array
`timescale 1ns/10ps
`default_nettype none
module otp_user_data_array_test;
    localparam logic [39:0] FACT0 = 40'h25_A5C3_1E2F;
    logic clk, rst, rd_req, rd_nib, pg_req, done, burn, rd_valid, ack, refused, ready;
    logic fcrc, ucrc, locked;
    logic [7:0] rd_addr, pg_addr, pg_data, dly, bdata, rd_data;
    logic [3:0] idx, nine;
    logic [2:0] range_field;
    logic [12:0] unit;
    logic [18:0] lot;
    logic [39:0] fact;
    logic [71:0] user;
    int n_errors = 0;
    int checks = 0;
    // reference crc over the factory bytes in address order
    function automatic logic [7:0] crc8(input logic [39:0] v);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < 40; i++)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i / 8 * 8 + 7 - i % 8]) ? 8'h07 : 8'h00);
        return c;
    endfunction
    ouda_array #(.FACT_CRC_REF(crc8(FACT0)), .USER_CRC_REF(8'h00)) dut (
        .CLK_IN(clk), .SRST_IN(rst), .FACT_OTP_IN(fact), .USER_OTP_IN(user),
        .SELF_CHECK_IN(8'h5a), .RD_REQ_IN(rd_req), .RD_NIBBLE_IN(rd_nib), .RD_ADDR_IN(rd_addr),
        .PROG_REQ_IN(pg_req), .PROG_ADDR_IN(pg_addr), .PROG_DATA_IN(pg_data),
        .OTP_BURN_OUT(burn), .OTP_BURN_IDX_OUT(idx), .OTP_BURN_DATA_OUT(bdata),
        .OTP_BURN_DONE_IN(done), .RD_VALID_OUT(rd_valid), .RD_DATA_OUT(rd_data),
        .PROG_ACK_OUT(ack), .PROG_REFUSED_OUT(refused), .READY_OUT(ready),
        .FACT_CRC_ERR_OUT(fcrc), .USER_CRC_ERR_OUT(ucrc), .USER_LOCKED_OUT(locked),
        .RANGE_FIELD_OUT(range_field), .INIT_NIBBLE_NINE_OUT(nine), .UNIT_COUNT_OUT(unit),
        .LOT_NUMBER_OUT(lot));
    ouda_otp_model otp (.clk_in(clk), .burn_in(burn), .idx_in(idx), .data_in(bdata),
        .delay_in(dly), .done_out(done), .user_out(user));
    // expected byte seen by the receiver
    function automatic logic [7:0] exp_byte(input logic [7:0] a);
        logic [71:0] t;
        t = user >> {a - 8'h05, 3'b000};
        if (a < 8'h04)
            return fact[{a[2:0], 3'b000} +: 8];
        if (a == 8'h04)
            return {5'b00100, fact[34:32]};
        if (a == 8'h0c)
            return 8'h5a;
        return (a <= 8'h0d) ? t[7:0] : 8'h00;
    endfunction
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task end_sim;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task wait_ready;
        for (int i = 0; i < 60 && ready !== 1'b1; i++)
            @(negedge clk);
        chk("ready", 1, ready);
    endtask
    // reset with new factory cells, one read sent while still loading
    task do_reset(input logic [39:0] v);
        @(posedge clk);
        rst <= 1'b1;
        fact <= v;
        rd_req <= 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_req <= 1'b0;
        @(negedge clk);
        chk("early_rd", 0, rd_valid);
        wait_ready;
    endtask
    task rd(input logic nib, input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        rd_req <= 1'b1;
        rd_nib <= nib;
        rd_addr <= a;
        @(posedge clk);
        rd_req <= 1'b0;
        @(negedge clk);
        chk("rd_valid", 1, rd_valid);
        chk("rd_data", e, rd_data);
    endtask
    task prog(input logic [7:0] a, input logic [7:0] d, input logic ok);
        @(posedge clk);
        pg_req <= 1'b1;
        pg_addr <= a;
        pg_data <= d;
        @(posedge clk);
        pg_req <= 1'b0;
        @(negedge clk);
        chk("refused", !ok, refused);
        chk("burn", ok, burn);
        if (ok) begin
            for (int i = 0; i < 60 && ack !== 1'b1; i++)
                @(negedge clk);
            chk("ack", 1, ack);
            wait_ready;
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #60000;
        n_errors++;
        end_sim;
    end
    initial begin
        {rst, fact, rd_req, rd_nib, rd_addr, pg_req, pg_addr, pg_data, dly} = {1'b1, 75'h0};
        for (int k = 0; k < 8; k++) begin
            do_reset({5'b00100, k[2:0], FACT0[31:0]});
            chk("range", k[2:0], range_field);
            chk("nine", (32'hA493_8271 >> (4 * k)) & 32'h0000_000f, nine);
            chk("fact_crc", k != 5, fcrc);
        end
        do_reset(FACT0 ^ 40'h0_0000_0001);
        chk("fact_crc", 1, fcrc);
        chk("user_crc", 0, ucrc);
        do_reset(FACT0);
        chk("fact_crc", 0, fcrc);
        chk("unit", FACT0[12:0], unit);
        chk("lot", FACT0[31:13], lot);
        prog(8'h02, 8'hff, 1'b0);
        prog(8'h0c, 8'hff, 1'b0);
        prog(8'h0e, 8'hff, 1'b0);
        dly = 8'h06;
        prog(8'h07, 8'h3c, 1'b1);
        rd(1'b0, 8'h07, 8'h3c);
        prog(8'h0d, 8'h9c, 1'b1);
        chk("user_crc", 1, ucrc);
        chk("fact_crc", 0, fcrc);
        dly = 8'h00;
        prog(8'h05, 8'h80, 1'b1);
        chk("locked", 1, locked);
        prog(8'h06, 8'h11, 1'b0);
        for (int a = 0; a < 16; a++)
            rd(1'b0, a[7:0], exp_byte(a[7:0]));
        for (int n = 0; n < 32; n++)
            rd(1'b1, n[7:0], {4'h0, n[0] ? exp_byte(n[8:1]) >> 4 : exp_byte(n[8:1]) & 8'h0f});
        end_sim;
    end
endmodule
bind ouda_array ouda_monitor mon (.CLK_IN, .SRST_IN, .RD_REQ_IN, .RD_NIBBLE_IN, .RD_ADDR_IN,
    .PROG_REQ_IN, .PROG_ADDR_IN, .OTP_BURN_DONE_IN, .OTP_BURN_OUT, .RD_VALID_OUT, .RD_DATA_OUT,
    .PROG_ACK_OUT, .PROG_REFUSED_OUT, .READY_OUT, .USER_LOCKED_OUT, .RANGE_FIELD_OUT,
    .INIT_NIBBLE_NINE_OUT);
`default_nettype wire
